// >>> fsac_pkg.sv
// flash self-access control: shared constants, field layouts and types
// assumes a 32-bit apb slave port with one register per aligned word
`default_nettype none

package fsac_pkg;

  // ****************************************************************
  // register byte offsets on the apb port
  // ****************************************************************
  localparam logic [7:0] OFF_DATA_LO = 8'h00; // memory_data_low
  localparam logic [7:0] OFF_DATA_HI = 8'h04; // memory_data_high
  localparam logic [7:0] OFF_ADDR_LO = 8'h08; // memory_address_low
  localparam logic [7:0] OFF_ADDR_HI = 8'h0C; // memory_address_high
  localparam logic [7:0] OFF_CTRL    = 8'h10; // flash_command_control
  localparam logic [7:0] OFF_KEY     = 8'h14; // flash_unlock_key

  // ****************************************************************
  // field positions, widths and reset values
  // ****************************************************************
  localparam int          WORD_W       = 14;       // memory word width
  localparam int          ADDR_W       = 15;       // memory pointer width
  localparam int          SEL_W        = 4;        // latch select width
  localparam int          NUM_LATCHES  = 16;       // write latches per row
  localparam int          NUM_UIDS     = 4;        // user id words
  localparam int          CTRL_RD      = 0;        // read command bit
  localparam int          CTRL_WR      = 1;        // write command bit
  localparam int          CTRL_ERASE   = 4;        // erase select bit
  localparam logic [6:0]  CTRL_RESET   = 7'h00;    // control bits at reset
  localparam logic [13:0] BLANK_WORD   = 14'h3FFF; // erased latch value
  localparam logic [7:0]  KEY_FIRST    = 8'h55;    // first unlock pattern
  localparam logic [7:0]  KEY_SECOND   = 8'hAA;    // second unlock pattern

  // config space word indices (pointer value with space select set)
  localparam logic [14:0] CFG_UID_LAST = 15'h0003; // last user id word
  localparam logic [14:0] CFG_REV_ID   = 15'h0005; // revision id
  localparam logic [14:0] CFG_DEV_ID   = 15'h0006; // device id
  localparam logic [14:0] CFG_WORD1    = 15'h0007; // configuration word 1
  localparam logic [14:0] CFG_WORD2    = 15'h0008; // configuration word 2

  // ****************************************************************
  // self-timed operation length
  // ****************************************************************
  localparam int PROG_TIME_NS  = 2000; // program or erase time
  localparam int CLK_PERIOD_NS = 4;    // pclk period
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic cfg;   // config_space_select
    logic llo;   // latch_load_only
    logic erase; // erase select
    logic err;   // program_error_flag
    logic pen;   // program_enable
    logic wr;    // write command
    logic rd;    // read command
  } fsac_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00, // no operation
    ST_LOAD   = 2'b10, // latch-only load finishing
    ST_TIMED  = 2'b01, // program or erase in progress
    ST_COMMIT = 2'b11  // row update and latch blanking
  } fsac_state_t;

  typedef enum logic [1:0] {
    KEY_NONE = 2'b00, // locked
    KEY_HALF = 2'b01, // first pattern seen
    KEY_OPEN = 2'b11  // both patterns seen in order
  } fsac_key_t;

endpackage

`default_nettype wire

// >>> fsac_top.sv
// flash self-access control: apb registers, unlock check, write latches,
// program memory array and config space words
// assumes an apb master on pclk; program memory contents start unknown
//
// Functional notes
// - space select picks config words or flash
// - bad config read clears both data registers
// - user ids read/write, ids and config read-only
// - 14-bit word split, high top bits zero
// - 15-bit pointer split, high top reads one
// - control top bit always reads one
// - latch-only writes latch, else program row
// - erase ignores the latch-only bit
// - erase select erases, cleared on completion
// - any write command attempt sets error flag
// - normal finish clears error, else stays set
// - program enable low blocks program and erase
// - write command self-timed, cleared when done
// - software cannot clear the write command
// - read command one cycle, hardware cleared
// - unlock register write-only, resets to zero
// - broken unlock blocks latch and flash
// - low four pointer bits pick latch in row
// - latches return to blank after each program or erase
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module fsac_top
  import fsac_pkg::*;
#(
  parameter int          PM_AW    = ADDR_W,   // program memory address bits
  parameter logic [13:0] DEV_ID   = 14'h0123, // arbitrary value
  parameter logic [13:0] REV_ID   = 14'h0001, // arbitrary value
  parameter logic [13:0] CFG_W1   = 14'h3FFF, // configuration word 1
  parameter logic [13:0] CFG_W2   = 14'h3FFF  // configuration word 2
) (
  input  wire logic        pclk,    // apb clock, 250 mhz
  input  wire logic        presetn, // async reset, active low
  input  wire logic        psel,    // apb select
  input  wire logic        penable, // apb access phase
  input  wire logic        pwrite,  // apb direction, high is write
  input  wire logic [7:0]  paddr,   // apb byte address
  input  wire logic [31:0] pwdata,  // apb write data
  output logic      [31:0] prdata,  // apb read data
  output logic             pready,  // apb ready, no wait states
  output logic             pslverr, // apb error on unmapped address
  output logic             busy     // program or erase in progress
);

  // ****************************************************************
  // storage and state
  // ****************************************************************
  localparam int ROW_W = PM_AW - SEL_W;        // row number width
  localparam int CNT_W = $clog2(PROG_CYCLES + 1); // timer width
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);

  logic [WORD_W-1:0] pm [2**PM_AW];       // program memory array
  logic [WORD_W-1:0] latch [NUM_LATCHES]; // row write latches
  logic [WORD_W-1:0] uid [NUM_UIDS];      // user id words
  logic [7:0]        data_lo;             // memory word bits 7:0
  logic [5:0]        data_hi;             // memory word bits 13:8
  logic [ADDR_W-1:0] ptr;                 // memory pointer
  fsac_ctrl_t        ctrl;                // control register bits
  fsac_key_t         key;                 // unlock progress
  fsac_state_t       state;               // operation state
  fsac_state_t       next_state;          // state for next cycle
  logic [CNT_W-1:0]  cnt;                 // self-timed counter
  logic              op_erase;            // captured erase select
  logic              op_cfg;              // captured space select
  logic [ROW_W-1:0]  op_row;              // captured row number
  logic [WORD_W-1:0] cfg_rword;           // config space read word
  logic [WORD_W-1:0] rd_word;             // word a read command loads
  logic [31:0]       next_prdata;         // read mux result
  logic              next_pslverr;        // unmapped address flag

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic       wr_acc;     // write completing this edge
  logic       setup;      // setup phase of any transfer
  logic       wr_ctrl;    // control register write
  logic       wr_attempt; // write command bit written as one
  logic       go_ok;      // write command accepted
  logic       go_latch;   // latch-only load accepted
  logic       go_flash;   // program or erase accepted
  fsac_ctrl_t wctl;       // written control fields

  assign wr_acc     = psel && penable && pwrite && pready;
  assign setup      = psel && !penable;
  assign wr_ctrl    = wr_acc && (paddr == OFF_CTRL);
  assign wctl       = fsac_ctrl_t'(pwdata[6:0]);
  assign wr_attempt = wr_ctrl && wctl.wr;
  // needs the full key, program enable and an idle unit
  assign go_ok      = wr_attempt && (key == KEY_OPEN) && wctl.pen
                      && (state == ST_IDLE);
  // latch-only is ignored when erase is selected
  assign go_latch   = go_ok && wctl.llo && !wctl.erase;
  assign go_flash   = go_ok && !go_latch;

  // ****************************************************************
  // unlock key tracking
  // ****************************************************************
  // any other write between the patterns and the command relocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key <= KEY_NONE;
    end else if (wr_acc) begin
      if (paddr == OFF_KEY && pwdata[7:0] == KEY_FIRST) begin
        key <= KEY_HALF;
      end else if (paddr == OFF_KEY && pwdata[7:0] == KEY_SECOND
                   && key == KEY_HALF) begin
        key <= KEY_OPEN;
      end else begin
        key <= KEY_NONE;  // consumed or interrupted
      end
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  // error and command bits: set wins over hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= fsac_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl.cfg <= wctl.cfg;
        ctrl.llo <= wctl.llo;
        ctrl.pen <= wctl.pen;
      end
      // read command lives one cycle, software cannot clear it
      ctrl.rd <= wr_ctrl && wctl.rd;
      // write command only set by an accepted start
      if (go_ok) begin
        ctrl.wr <= 1'b1;
      end else if (state == ST_LOAD || state == ST_COMMIT) begin
        ctrl.wr <= 1'b0;  // writes of zero never reach here
      end
      // every attempt flags error until a normal finish
      if (wr_attempt) begin
        ctrl.err <= 1'b1;
      end else if (state == ST_LOAD || state == ST_COMMIT) begin
        ctrl.err <= 1'b0;
      end
      // erase select cleared by hardware once the erase is done
      if (wr_ctrl && wctl.erase) begin
        ctrl.erase <= 1'b1;
      end else if (state == ST_COMMIT && op_erase) begin
        ctrl.erase <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl.erase <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // operation sequencer
  // ****************************************************************
  // next state: latch load one cycle, flash op timed then committed
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (go_latch) begin
          next_state = ST_LOAD;
        end else if (go_flash) begin
          next_state = ST_TIMED;
        end
      end
      ST_LOAD: begin
        next_state = ST_IDLE;
      end
      ST_TIMED: begin
        if (cnt == CNT_LAST) begin
          next_state = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // self-timed counter, runs only during the timed phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (state == ST_TIMED) begin
      cnt <= cnt + CNT_W'(1);
    end else begin
      cnt <= '0;
    end
  end

  // operation capture so later register writes cannot steer it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_erase <= 1'b0;
      op_cfg   <= 1'b0;
      op_row   <= '0;
    end else if (go_flash) begin
      op_erase <= wctl.erase;
      op_cfg   <= wctl.cfg;
      op_row   <= ptr[PM_AW-1:SEL_W];  // row never crossed
    end
  end

  // busy output for a processor stall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state == ST_TIMED) || (next_state == ST_COMMIT);
    end
  end

  // ****************************************************************
  // write latches
  // ****************************************************************
  // addressed latch loaded on any accepted non-erase start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_LATCHES; i++) begin
        latch[i] <= BLANK_WORD;
      end
    end else if (state == ST_COMMIT) begin
      for (int i = 0; i < NUM_LATCHES; i++) begin
        latch[i] <= BLANK_WORD;
      end
    end else if (go_ok && !wctl.erase) begin
      latch[ptr[SEL_W-1:0]] <= {data_hi, data_lo};
    end
  end

  // ****************************************************************
  // program memory and user id words
  // ****************************************************************
  // whole row written from latches, or blanked by erase
  always_ff @(posedge pclk) begin
    if (state == ST_COMMIT && !op_cfg) begin
      for (int i = 0; i < NUM_LATCHES; i++) begin
        pm[{op_row, SEL_W'(i)}] <= op_erase ? BLANK_WORD : latch[i];
      end
    end
  end

  // only user ids are writable in config space
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_UIDS; i++) begin
        uid[i] <= BLANK_WORD;
      end
    end else if (state == ST_COMMIT && op_cfg && op_row == '0) begin
      for (int i = 0; i < NUM_UIDS; i++) begin
        uid[i] <= op_erase ? BLANK_WORD : latch[i];
      end
    end
  end

  // ****************************************************************
  // read path into the data registers
  // ****************************************************************
  // config space lookup, holes read as zero
  always_comb begin
    cfg_rword = '0;
    if (ptr <= CFG_UID_LAST) begin
      cfg_rword = uid[ptr[1:0]];
    end else if (ptr == CFG_REV_ID) begin
      cfg_rword = REV_ID;
    end else if (ptr == CFG_DEV_ID) begin
      cfg_rword = DEV_ID;
    end else if (ptr == CFG_WORD1) begin
      cfg_rword = CFG_W1;
    end else if (ptr == CFG_WORD2) begin
      cfg_rword = CFG_W2;
    end
  end

  // space select picks the source
  assign rd_word = ctrl.cfg ? cfg_rword : pm[ptr[PM_AW-1:0]];

  // data registers: read command load wins over software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_lo <= '0;
      data_hi <= '0;
    end else if (ctrl.rd) begin
      data_lo <= rd_word[7:0];
      data_hi <= rd_word[13:8];
    end else if (wr_acc && paddr == OFF_DATA_LO) begin
      data_lo <= pwdata[7:0];
    end else if (wr_acc && paddr == OFF_DATA_HI) begin
      data_hi <= pwdata[5:0];
    end
  end

  // memory pointer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= '0;
    end else if (wr_acc && paddr == OFF_ADDR_LO) begin
      ptr[7:0] <= pwdata[7:0];
    end else if (wr_acc && paddr == OFF_ADDR_HI) begin
      ptr[14:8] <= pwdata[6:0];
    end
  end

  // ****************************************************************
  // apb slave answer
  // ****************************************************************
  // read mux, sampled in the setup phase
  always_comb begin
    next_prdata  = '0;
    next_pslverr = 1'b0;
    if (paddr == OFF_DATA_LO) begin
      next_prdata[7:0] = data_lo;
    end else if (paddr == OFF_DATA_HI) begin
      next_prdata[5:0] = data_hi;  // bits 7:6 read zero
    end else if (paddr == OFF_ADDR_LO) begin
      next_prdata[7:0] = ptr[7:0];
    end else if (paddr == OFF_ADDR_HI) begin
      next_prdata[7:0] = {1'b1, ptr[14:8]};
    end else if (paddr == OFF_CTRL) begin
      next_prdata[7:0] = {1'b1, ctrl};
    end else if (paddr == OFF_KEY) begin
      next_prdata = '0;  // write-only, nothing stored
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // no wait state: answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && next_pslverr;
      prdata  <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  logic acc_rd; // read access completing
  assign acc_rd = psel && penable && pready && !pwrite;

  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_addr_high_top;
    acc_rd && paddr == OFF_ADDR_HI |-> prdata[31:7] == 25'h0000001;
  endproperty
  a_addr_high_top: assert property (p_addr_high_top)
    else $error("pointer high top bit not one");

  property p_ctrl_top;
    acc_rd && paddr == OFF_CTRL |-> prdata[7] && prdata[31:8] == '0;
  endproperty
  a_ctrl_top: assert property (p_ctrl_top)
    else $error("control top bit not one");

  property p_data_high_zero;
    acc_rd && paddr == OFF_DATA_HI |-> prdata[31:6] == '0;
  endproperty
  a_data_high_zero: assert property (p_data_high_zero)
    else $error("data high top bits not zero");

  property p_key_reads_zero;
    acc_rd && paddr == OFF_KEY |-> prdata == '0;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero)
    else $error("unlock register readable");

  property p_rd_pulse;
    wr_ctrl && wctl.rd |=> ctrl.rd ##1 !ctrl.rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read command not a one cycle pulse");

  property p_blocked_start;
    wr_attempt && key != KEY_OPEN |=> ctrl.err && state == ST_IDLE
      ##1 latch[0] == $past(latch[0]);
  endproperty
  a_blocked_start: assert property (p_blocked_start)
    else $error("start without unlock acted");

  property p_no_pen_no_op;
    wr_attempt && !wctl.pen |=> state == ST_IDLE && !ctrl.wr;
  endproperty
  a_no_pen_no_op: assert property (p_no_pen_no_op)
    else $error("operation with program enable low");

  // cycles since the last flash start, too long for a plain delay
  logic [CNT_W-1:0] op_age; // helper age counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_age <= '0;
    end else if (go_flash) begin
      op_age <= '0;  // restart on each accepted flash start
    end else if (state == ST_TIMED) begin
      op_age <= op_age + CNT_W'(1);
    end
  end

  property p_flash_start;
    go_flash |=> ctrl.wr && ctrl.err && busy;
  endproperty
  a_flash_start: assert property (p_flash_start)
    else $error("flash operation start flags wrong");

  property p_flash_time;
    state == ST_TIMED || state == ST_COMMIT
      |-> (state == ST_COMMIT) == (op_age == CNT_W'(PROG_CYCLES));
  endproperty
  a_flash_time: assert property (p_flash_time)
    else $error("flash operation length wrong");

  property p_flash_done;
    state == ST_COMMIT && !wr_attempt |=> !ctrl.wr && !ctrl.err && !busy;
  endproperty
  a_flash_done: assert property (p_flash_done)
    else $error("flash operation completion wrong");

  property p_erase_clears;
    state == ST_COMMIT && op_erase && !wr_ctrl |=> !ctrl.erase;
  endproperty
  a_erase_clears: assert property (p_erase_clears)
    else $error("erase select not cleared");

  property p_latch_blank;
    state == ST_COMMIT |=> latch[0] == BLANK_WORD
      && latch[NUM_LATCHES-1] == BLANK_WORD;
  endproperty
  a_latch_blank: assert property (p_latch_blank)
    else $error("latches not blank after operation");

  property p_bad_cfg_read;
    ctrl.rd && ctrl.cfg && ptr > CFG_WORD2 |=> data_lo == '0 && data_hi == '0;
  endproperty
  a_bad_cfg_read: assert property (p_bad_cfg_read)
    else $error("bad config read not cleared");

endmodule

`default_nettype wire

// >>> tb_flash_self_access_control.sv
// self-checking bench for the flash self-access control block
// assumes fsac_top on a 250 mhz pclk, driven directly over apb
`timescale 1ns/1ps
`default_nettype none

module tb_flash_self_access_control;
  import fsac_pkg::*;
  // ****************************************************************
  // signals and bookkeeping
  // ****************************************************************
  localparam logic [13:0] DEV = 14'h0155; // arbitrary value
  localparam int          NR  = 20;       // table rows
  logic        pclk       = 1'b0;  // apb clock
  logic        presetn    = 1'b0;  // reset, active low
  logic        psel       = 1'b0;  // select
  logic        penable    = 1'b0;  // access phase
  logic        pwrite     = 1'b0;  // direction
  logic [7:0]  paddr      = 8'h00; // byte address
  logic [31:0] pwdata     = 32'h0; // write data
  logic [31:0] prdata;             // read data
  logic        pready;             // ready
  logic        pslverr;            // slave error
  logic        busy;               // operation running
  logic [31:0] r;                  // last read data
  logic        e;                  // last slave error
  int          n_mismatch = 0;     // mismatches
  int          checks     = 0;     // comparisons
  int          cyc        = 0;     // cycles for the timeout
  // row: write, offset, write data, slave error, read byte
  logic [25:0] rows [NR] = '{
    {1'b0,8'h00,8'h00,1'b0,8'h00}, {1'b0,8'h04,8'h00,1'b0,8'h00},
    {1'b0,8'h08,8'h00,1'b0,8'h00}, {1'b0,8'h0C,8'h00,1'b0,8'h80},
    {1'b0,8'h10,8'h00,1'b0,8'h80}, {1'b0,8'h14,8'h00,1'b0,8'h00},
    {1'b1,8'h04,8'hFF,1'b0,8'h00}, {1'b0,8'h04,8'h00,1'b0,8'h3F},
    {1'b1,8'h0C,8'hFF,1'b0,8'h00}, {1'b0,8'h0C,8'h00,1'b0,8'hFF},
    {1'b1,8'h0C,8'h00,1'b0,8'h00}, {1'b0,8'h0C,8'h00,1'b0,8'h80},
    {1'b1,8'h10,8'h40,1'b0,8'h00}, {1'b0,8'h10,8'h00,1'b0,8'hC0},
    {1'b1,8'h10,8'h00,1'b0,8'h00}, {1'b0,8'h10,8'h00,1'b0,8'h80},
    {1'b1,8'h14,8'h55,1'b0,8'h00}, {1'b0,8'h14,8'h00,1'b0,8'h00},
    {1'b0,8'h18,8'h00,1'b1,8'h00}, {1'b1,8'h18,8'h00,1'b1,8'h00}};

  fsac_top #(.DEV_ID(DEV)) fsac_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy));

  // clock and hang guard
  initial forever #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    cmp({e, r}, {1'b0, 24'h0, x});
  endtask
  // pointer and data registers
  task automatic ld(input logic [14:0] p, input logic [13:0] x);
    apb(1'b1, OFF_ADDR_LO, p[7:0]);
    apb(1'b1, OFF_ADDR_HI, {1'b0, p[14:8]});
    apb(1'b1, OFF_DATA_LO, x[7:0]);
    apb(1'b1, OFF_DATA_HI, {2'b00, x[13:8]});
  endtask
  // unlock pair then control write
  task automatic op(input logic [7:0] k, input logic [7:0] c);
    apb(1'b1, OFF_KEY, KEY_FIRST);
    apb(1'b1, OFF_KEY, k);
    apb(1'b1, OFF_CTRL, c);
  endtask
  task automatic idle(input logic bx);
    @(posedge pclk);
    cmp({32'h0, busy}, {32'h0, bx});
    while (busy === 1'b1) @(posedge pclk);
  endtask
  // read command then both data registers
  task automatic rw(input logic [14:0] p, input logic g, input logic [13:0] x);
    ld(p, ~x);
    apb(1'b1, OFF_CTRL, {1'b0, g, 6'h05});
    @(posedge pclk);
    rc(OFF_DATA_LO, x[7:0]);
    rc(OFF_DATA_HI, {2'b00, x[13:8]});
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NR; i++) begin
      apb(rows[i][25], rows[i][24:17], rows[i][16:9]);
      cmp({e, rows[i][25] ? 32'h0 : r}, {rows[i][8], 24'h0, rows[i][7:0]});
    end
    $display("test registers done");
    ld(15'h0012, 14'h1234);
    op(KEY_SECOND, 8'h26);
    idle(1'b0);
    rc(OFF_CTRL, 8'hA4);
    ld(15'h0013, 14'h0ABC);
    op(KEY_SECOND, 8'h06);
    apb(1'b1, OFF_CTRL, 8'h04);
    rc(OFF_CTRL, 8'h8E);
    idle(1'b1);
    rc(OFF_CTRL, 8'h84);
    rw(15'h0013, 1'b0, 14'h0ABC);
    rw(15'h0012, 1'b0, 14'h1234);
    rw(15'h0011, 1'b0, BLANK_WORD);
    rc(OFF_CTRL, 8'h84);
    $display("test program done");
    ld(15'h0013, 14'h0001);
    op(KEY_SECOND, 8'h02);
    idle(1'b0);
    rc(OFF_CTRL, 8'h88);
    op(8'h54, 8'h06);
    idle(1'b0);
    rc(OFF_CTRL, 8'h8C);
    rw(15'h0013, 1'b0, 14'h0ABC);
    op(KEY_SECOND, 8'h36);
    idle(1'b1);
    rc(OFF_CTRL, 8'hA4);
    rw(15'h0013, 1'b0, BLANK_WORD);
    $display("test blocked and erase done");
    rw(15'h0006, 1'b1, DEV);
    rw(15'h0004, 1'b1, 14'h0000);
    rw(15'h0009, 1'b1, 14'h0000);
    rw(15'h0000, 1'b1, BLANK_WORD);
    ld(15'h0001, 14'h2A5C);
    op(KEY_SECOND, 8'h46);
    idle(1'b1);
    rw(15'h0001, 1'b1, 14'h2A5C);
    ld(15'h0006, 14'h0000);
    op(KEY_SECOND, 8'h46);
    idle(1'b1);
    rw(15'h0006, 1'b1, DEV);
    $display("test config space done");
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(OFF_CTRL, 8'h80);
    rc(OFF_ADDR_HI, 8'h80);
    $display("test second reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
